// ==== hdl/frml_pkg.sv ====
// constants for the fault report mask and latch block
package frml_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CHAN_STATUS = 8'h70;
  localparam logic [7:0] ADDR_GLOBAL_STATUS1 = 8'h71;
  localparam logic [7:0] ADDR_GLOBAL_STATUS2 = 8'h72;
  localparam logic [7:0] ADDR_WARN_STATUS = 8'h73;
  localparam logic [7:0] ADDR_REPORT_MASK = 8'h74;
  localparam logic [7:0] ADDR_LATCH_CONTROL = 8'h75;
  localparam logic [7:0] ADDR_MISC_CONTROL = 8'h76;
  localparam logic [7:0] ADDR_CLEAR_COMMAND = 8'h78;
  // reset values
  localparam logic [7:0] RST_REPORT_MASK = 8'h00;
  localparam logic [7:0] RST_LATCH_CONTROL = 8'hf8;
  localparam logic [7:0] RST_MISC_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLEAR_COMMAND = 8'h00;
  // report mask fields
  localparam int OVERTEMP_SHUTDOWN_REPORT_MASK_BIT = 7;
  localparam int MASK_LOGIC_LOW_BIT = 6;
  localparam int MASK_LOGIC_HIGH_BIT = 5;
  localparam int MASK_CLOCK_BIT = 4;
  localparam int MASK_POWER_LOW_BIT = 3;
  localparam int MASK_POWER_HIGH_BIT = 2;
  localparam int MASK_OFFSET_BIT = 1;
  localparam int MASK_OVERCURRENT_BIT = 0;
  // latch control fields
  localparam int HOLD_CLOCK_BIT = 5;
  localparam int HOLD_OVERTEMP_SHUTDOWN_BIT = 4;
  localparam int HOLD_OTW_BIT = 3;
  localparam int OVERTEMP_WARNING_REPORT_MASK_BIT = 2;
  // misc control fields
  localparam int CLOCK_DETECT_HOLD_BIT = 7;
  localparam int AUTO_RECOVERY_BIT = 4;
  // clear command field
  localparam int ANALOG_CLEAR_BIT = 7;
  // status register fields
  localparam int RIGHT_OC_BIT = 0;
  localparam int LEFT_OC_BIT = 1;
  localparam int RIGHT_DC_BIT = 2;
  localparam int LEFT_DC_BIT = 3;
  localparam int STAT_POWER_LOW_BIT = 0;
  localparam int STAT_POWER_HIGH_BIT = 1;
  localparam int STAT_CLOCK_BIT = 2;
  localparam int STAT_OVERTEMP_SHUTDOWN_BIT = 0;
  localparam int STAT_OTW_BIT = 2;
  // fault source indices
  localparam int SRC_COUNT = 11;
  localparam int SRC_LEFT_OC = 0;
  localparam int SRC_RIGHT_OC = 1;
  localparam int SRC_LEFT_DC = 2;
  localparam int SRC_RIGHT_DC = 3;
  localparam int SRC_POWER_HIGH = 4;
  localparam int SRC_POWER_LOW = 5;
  localparam int SRC_CLOCK = 6;
  localparam int SRC_LOGIC_HIGH = 7;
  localparam int SRC_LOGIC_LOW = 8;
  localparam int SRC_OVERTEMP_SHUTDOWN = 9;
  localparam int SRC_OTW = 10;
endpackage

// ==== hdl/frml_fault_cell.sv ====
// one fault source: optional hold, clear and report gating
module frml_fault_cell (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // control
  input wire logic raw_in,
  input wire logic hold_enable_in,
  input wire logic clear_in,
  input wire logic report_mask_in,
  // result
  output logic status_out,
  output logic report_out
);
  logic held;
  logic next_held;

  // set wins over a simultaneous clear
  always_comb begin
    next_held = held;
    if (clear_in || !hold_enable_in) begin
      next_held = 1'b0;
    end
    if (raw_in && hold_enable_in) begin
      next_held = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      held <= 1'b0;
    end else begin
      held <= next_held;
    end
  end

  always_comb begin
    status_out = raw_in | held;
    report_out = (raw_in | held) & ~report_mask_in;
  end
endmodule // frml_fault_cell

// ==== hdl/frml_fault_report.sv ====
// fault report masking, latching and clearing with register port
// Functional notes
// RULE_01 - mask bit 7 hides shutdown; reset zero
// RULE_02 - mask bit 6 hides logic undervoltage
// RULE_03 - mask bit 5 hides logic overvoltage
// RULE_04 - mask bit 4 hides clock fault
// RULE_05 - mask bit 3 hides power undervoltage
// RULE_06 - mask bit 2 hides power overvoltage
// RULE_07 - mask bit 1 hides DC fault
// RULE_08 - mask bit 0 hides overcurrent
// RULE_09 - latch bit 5 holds clock fault
// RULE_10 - latch bit 4 holds shutdown fault
// RULE_11 - latch bit 3 holds temperature warning
// RULE_12 - latch bit 2 hides temperature warning
// RULE_13 - latch control resets to f8
// RULE_14 - misc bit 7 holds clock detect status
// RULE_15 - misc bit 4 enables shutdown auto recovery
// RULE_16 - writing clear bit 7 releases held faults
// RULE_17 - channel status shows per-side OC, DC
// RULE_18 - global status bit 0 shows shutdown
// RULE_19 - one report output combines unmasked faults
// RULE_20 - held faults stay until clear written
module frml_fault_report (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // raw detector levels
  input wire logic left_overcurrent_in,
  input wire logic right_overcurrent_in,
  input wire logic left_offset_in,
  input wire logic right_offset_in,
  input wire logic power_stage_supply_high_in,
  input wire logic power_stage_supply_low_in,
  input wire logic clock_failure_in,
  input wire logic logic_supply_high_in,
  input wire logic logic_supply_low_in,
  input wire logic overtemp_shutdown_in,
  input wire logic overtemp_warning_in,
  // results
  output logic fault_report_out,
  output logic overtemp_shutdown_active_out,
  output logic analog_clear_out
);
  logic [7:0] fault_report_mask;
  logic [7:0] fault_latch_control;
  logic [7:0] fault_misc_control;
  logic [7:0] fault_clear_command;
  logic [frml_pkg::SRC_COUNT-1:0] raw;
  logic [frml_pkg::SRC_COUNT-1:0] hold_en;
  logic [frml_pkg::SRC_COUNT-1:0] mask;
  logic [frml_pkg::SRC_COUNT-1:0] status;
  logic [frml_pkg::SRC_COUNT-1:0] report;
  logic clear_pulse;
  logic [7:0] next_rdata;

  function automatic logic is_write(input logic [7:0] addr, input logic [7:0] target);
    is_write = reg_write_in && (addr == target);
  endfunction

  // mask, latch and misc registers
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      fault_report_mask <= frml_pkg::RST_REPORT_MASK; // [RULE_01]
      fault_latch_control <= frml_pkg::RST_LATCH_CONTROL; // [RULE_13]
      fault_misc_control <= frml_pkg::RST_MISC_CONTROL;
    end else begin
      if (is_write(reg_addr_in, frml_pkg::ADDR_REPORT_MASK)) begin
        fault_report_mask <= reg_wdata_in;
      end
      if (is_write(reg_addr_in, frml_pkg::ADDR_LATCH_CONTROL)) begin
        fault_latch_control <= reg_wdata_in;
      end
      if (is_write(reg_addr_in, frml_pkg::ADDR_MISC_CONTROL)) begin
        fault_misc_control <= reg_wdata_in;
      end
    end
  end

  // clear bit is write-only; low bits are plain storage
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      fault_clear_command <= frml_pkg::RST_CLEAR_COMMAND;
    end else if (is_write(reg_addr_in, frml_pkg::ADDR_CLEAR_COMMAND)) begin
      fault_clear_command <= {1'b0, reg_wdata_in[6:0]};
    end
  end

  // one-cycle clear pulse from a write of one
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= is_write(reg_addr_in, frml_pkg::ADDR_CLEAR_COMMAND)
        && reg_wdata_in[frml_pkg::ANALOG_CLEAR_BIT]; // [RULE_16]
    end
  end

  always_comb begin
    raw = '0;
    raw[frml_pkg::SRC_LEFT_OC] = left_overcurrent_in;
    raw[frml_pkg::SRC_RIGHT_OC] = right_overcurrent_in;
    raw[frml_pkg::SRC_LEFT_DC] = left_offset_in;
    raw[frml_pkg::SRC_RIGHT_DC] = right_offset_in;
    raw[frml_pkg::SRC_POWER_HIGH] = power_stage_supply_high_in;
    raw[frml_pkg::SRC_POWER_LOW] = power_stage_supply_low_in;
    raw[frml_pkg::SRC_CLOCK] = clock_failure_in;
    raw[frml_pkg::SRC_LOGIC_HIGH] = logic_supply_high_in;
    raw[frml_pkg::SRC_LOGIC_LOW] = logic_supply_low_in;
    raw[frml_pkg::SRC_OVERTEMP_SHUTDOWN] = overtemp_shutdown_in;
    raw[frml_pkg::SRC_OTW] = overtemp_warning_in;
  end

  // protection faults other than clock and temperature always hold until cleared
  always_comb begin
    hold_en = '1; // [RULE_20]
    hold_en[frml_pkg::SRC_CLOCK] = fault_latch_control[frml_pkg::HOLD_CLOCK_BIT]
      & fault_misc_control[frml_pkg::CLOCK_DETECT_HOLD_BIT]; // [RULE_09] [RULE_14]
    // auto recovery lets the shutdown flag follow the detector
    hold_en[frml_pkg::SRC_OVERTEMP_SHUTDOWN] = fault_latch_control[frml_pkg::HOLD_OVERTEMP_SHUTDOWN_BIT]
      & ~fault_misc_control[frml_pkg::AUTO_RECOVERY_BIT]; // [RULE_10] [RULE_15]
    hold_en[frml_pkg::SRC_OTW] = fault_latch_control[frml_pkg::HOLD_OTW_BIT]; // [RULE_11]
  end

  always_comb begin
    mask = '0;
    mask[frml_pkg::SRC_OVERTEMP_SHUTDOWN] = fault_report_mask[frml_pkg::OVERTEMP_SHUTDOWN_REPORT_MASK_BIT]; // [RULE_01]
    mask[frml_pkg::SRC_LOGIC_LOW] = fault_report_mask[frml_pkg::MASK_LOGIC_LOW_BIT]; // [RULE_02]
    mask[frml_pkg::SRC_LOGIC_HIGH] = fault_report_mask[frml_pkg::MASK_LOGIC_HIGH_BIT]; // [RULE_03]
    mask[frml_pkg::SRC_CLOCK] = fault_report_mask[frml_pkg::MASK_CLOCK_BIT]; // [RULE_04]
    mask[frml_pkg::SRC_POWER_LOW] = fault_report_mask[frml_pkg::MASK_POWER_LOW_BIT]; // [RULE_05]
    mask[frml_pkg::SRC_POWER_HIGH] = fault_report_mask[frml_pkg::MASK_POWER_HIGH_BIT]; // [RULE_06]
    mask[frml_pkg::SRC_LEFT_DC] = fault_report_mask[frml_pkg::MASK_OFFSET_BIT]; // [RULE_07]
    mask[frml_pkg::SRC_RIGHT_DC] = fault_report_mask[frml_pkg::MASK_OFFSET_BIT]; // [RULE_07]
    mask[frml_pkg::SRC_LEFT_OC] = fault_report_mask[frml_pkg::MASK_OVERCURRENT_BIT]; // [RULE_08]
    mask[frml_pkg::SRC_RIGHT_OC] = fault_report_mask[frml_pkg::MASK_OVERCURRENT_BIT]; // [RULE_08]
    mask[frml_pkg::SRC_OTW] = fault_latch_control[frml_pkg::OVERTEMP_WARNING_REPORT_MASK_BIT]; // [RULE_12]
  end

  genvar g;
  generate
    for (g = 0; g < frml_pkg::SRC_COUNT; g = g + 1) begin : g_cell
      frml_fault_cell u_cell (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .raw_in(raw[g]),
        .hold_enable_in(hold_en[g]),
        .clear_in(clear_pulse), // [RULE_16]
        .report_mask_in(mask[g]),
        .status_out(status[g]),
        .report_out(report[g])
      );
    end
  endgenerate

  // read mux; unmapped reads return zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_in)
      frml_pkg::ADDR_CHAN_STATUS: begin
        next_rdata[frml_pkg::LEFT_OC_BIT] = status[frml_pkg::SRC_LEFT_OC]; // [RULE_17]
        next_rdata[frml_pkg::RIGHT_OC_BIT] = status[frml_pkg::SRC_RIGHT_OC]; // [RULE_17]
        next_rdata[frml_pkg::LEFT_DC_BIT] = status[frml_pkg::SRC_LEFT_DC]; // [RULE_17]
        next_rdata[frml_pkg::RIGHT_DC_BIT] = status[frml_pkg::SRC_RIGHT_DC]; // [RULE_17]
      end
      frml_pkg::ADDR_GLOBAL_STATUS1: begin
        next_rdata[frml_pkg::STAT_POWER_LOW_BIT] = status[frml_pkg::SRC_POWER_LOW];
        next_rdata[frml_pkg::STAT_POWER_HIGH_BIT] = status[frml_pkg::SRC_POWER_HIGH];
        next_rdata[frml_pkg::STAT_CLOCK_BIT] = status[frml_pkg::SRC_CLOCK];
      end
      frml_pkg::ADDR_GLOBAL_STATUS2: begin
        next_rdata[frml_pkg::STAT_OVERTEMP_SHUTDOWN_BIT] = status[frml_pkg::SRC_OVERTEMP_SHUTDOWN]; // [RULE_18]
      end
      frml_pkg::ADDR_WARN_STATUS: begin
        next_rdata[frml_pkg::STAT_OTW_BIT] = status[frml_pkg::SRC_OTW];
      end
      frml_pkg::ADDR_REPORT_MASK: next_rdata = fault_report_mask;
      frml_pkg::ADDR_LATCH_CONTROL: next_rdata = fault_latch_control;
      frml_pkg::ADDR_MISC_CONTROL: next_rdata = fault_misc_control;
      frml_pkg::ADDR_CLEAR_COMMAND: next_rdata = fault_clear_command;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      fault_report_out <= 1'b0;
      overtemp_shutdown_active_out <= 1'b0;
      analog_clear_out <= 1'b0;
    end else begin
      fault_report_out <= |report; // [RULE_19]
      overtemp_shutdown_active_out <= status[frml_pkg::SRC_OVERTEMP_SHUTDOWN];
      analog_clear_out <= clear_pulse;
    end
  end
endmodule // frml_fault_report

// ==== verif/frml_fault_report_props.sv ====
// checker for the fault report block ports
module frml_fault_report_props (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // detectors and results
  input wire logic left_overcurrent_in,
  input wire logic overtemp_shutdown_in,
  input wire logic fault_report_out,
  input wire logic overtemp_shutdown_active_out,
  input wire logic analog_clear_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [7:0] mask;
  logic clr_now;
  assign clr_now = reg_write_in && reg_addr_in == frml_pkg::ADDR_CLEAR_COMMAND && reg_wdata_in[7];
  // shadow of the mask so masking can be judged from the ports alone
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) mask <= 8'h00;
    else if (reg_write_in && reg_addr_in == frml_pkg::ADDR_REPORT_MASK) mask <= reg_wdata_in;
  end
  sequence oc_live;
    left_overcurrent_in && !mask[0];
  endsequence
  sequence clr_quiet;
    (clr_now && !overtemp_shutdown_in) ##1 (!overtemp_shutdown_in) [*3];
  endsequence
  a_clear_pulse_shape: assert property (clr_now |=> ##1 analog_clear_out ##1 !analog_clear_out)
    else $error("clear pulse misplaced");
  a_clear_has_cause: assert property (analog_clear_out |-> $past(clr_now, 2))
    else $error("clear pulse without write");
  a_rdata_holds: assert property (!$past(reg_read_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (reg_read_in && reg_addr_in == 8'h77 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_mask_read_back: assert property (reg_read_in && reg_addr_in == 8'h74 |=> reg_rdata_out == mask)
    else $error("mask read back wrong");
  a_oc_reported: assert property (oc_live [*3] |=> fault_report_out)
    else $error("unmasked overcurrent not reported");
  a_overtemp_shutdown_follows: assert property (overtemp_shutdown_in [*2] |=> overtemp_shutdown_active_out)
    else $error("shutdown not shown");
  a_overtemp_shutdown_origin: assert property ($rose(overtemp_shutdown_active_out) |-> $past(overtemp_shutdown_in))
    else $error("shutdown shown without cause");
  a_overtemp_shutdown_release: assert property (clr_quiet |=> !overtemp_shutdown_active_out)
    else $error("shutdown held after clear");
endmodule // frml_fault_report_props
bind frml_fault_report frml_fault_report_props u_props (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .left_overcurrent_in(left_overcurrent_in), .overtemp_shutdown_in(overtemp_shutdown_in),
  .fault_report_out(fault_report_out), .overtemp_shutdown_active_out(overtemp_shutdown_active_out),
  .analog_clear_out(analog_clear_out)
);

// ==== verif/frml_host.sv ====
// host model driving the register port
module frml_host (
  // clock
  input wire logic sys_clk_in,
  // register port
  output logic [7:0] reg_addr_out,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
  end
  // idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_write_out = 1'b1;
    @(negedge sys_clk_in);
    reg_write_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_read_out = 1'b1;
    @(negedge sys_clk_in);
    reg_read_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask
  task automatic clr();
    wr(frml_pkg::ADDR_CLEAR_COMMAND, 8'h80);
  endtask
endmodule // frml_host

// ==== verif/frml_fault_report_tb.sv ====
// self-checking bench for the fault report block
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module frml_fault_report_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, resetn_in, reg_write, reg_read, fault_report, overtemp_shutdown_active, analog_clear;
  logic [7:0] reg_addr, reg_wdata, rdata, m, l, c, d;
  logic [10:0] raw, held, hen, mv, flag;
  logic [31:0] seed = 32'h1c25dd38;
  logic [7:0] ra [5] = '{8'h74, 8'h75, 8'h76, 8'h78, 8'h77};
  logic [7:0] rv [5] = '{8'h00, 8'hf8, 8'h00, 8'h00, 8'h00};
  int n_fail = 0, checks = 0;
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  frml_host h (.sys_clk_in(sys_clk_in), .reg_addr_out(reg_addr), .reg_write_out(reg_write),
    .reg_read_out(reg_read), .reg_wdata_out(reg_wdata), .reg_rdata_in(rdata));
  frml_fault_report dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
    .reg_write_in(reg_write), .reg_read_in(reg_read), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
    .left_overcurrent_in(raw[0]), .right_overcurrent_in(raw[1]), .left_offset_in(raw[2]),
    .right_offset_in(raw[3]), .power_stage_supply_high_in(raw[4]), .power_stage_supply_low_in(raw[5]),
    .clock_failure_in(raw[6]), .logic_supply_high_in(raw[7]), .logic_supply_low_in(raw[8]),
    .overtemp_shutdown_in(raw[9]), .overtemp_warning_in(raw[10]), .fault_report_out(fault_report),
    .overtemp_shutdown_active_out(overtemp_shutdown_active), .analog_clear_out(analog_clear));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // supplies, offset and overcurrent always hold; the rest by enables
  task automatic upd();
    hen = 11'h1bf;
    hen[6] = l[5] & c[7];
    hen[9] = l[4] & ~c[4];
    hen[10] = l[3];
    mv = {l[2], m[7], m[6], m[5], m[4], m[3], m[2], m[1], m[1], m[0], m[0]};
    held = held | (raw & hen);
    flag = raw | (held & hen);
  endtask
  task automatic chk_out();
    `CHK(fault_report, |(flag & ~mv))
    `CHK(overtemp_shutdown_active, flag[9])
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    resetn_in = 1'b0;
    raw = '0;
    held = '0;
    repeat (10) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    for (int i = 0; i < 5; i++) begin
      h.rd(ra[i], d);
      `CHK(d, rv[i])
    end
    h.wr(8'h70, 8'hff);
    h.rd(8'h70, d);
    `CHK(d, 8'h00)
    h.wr(8'h78, 8'hff);
    h.rd(8'h78, d);
    `CHK(d, 8'h7f)
    $display("reset test done");
    for (int it = 0; it < 40; it++) begin
      seed = xs(seed);
      {c, l, m} = seed[23:0];
      h.wr(8'h74, m);
      h.wr(8'h75, l);
      h.wr(8'h76, c);
      h.rd(8'h75, d);
      `CHK(d, l)
      seed = xs(seed);
      raw = seed[10:0] & seed[26:16];
      upd();
      repeat (3) @(negedge sys_clk_in);
      chk_out();
      raw = '0;
      upd();
      repeat (3) @(negedge sys_clk_in);
      chk_out();
      h.rd(8'h70, d);
      `CHK(d, {4'h0, flag[2], flag[3], flag[0], flag[1]})
      h.rd(8'h72, d);
      `CHK(d, {7'h00, flag[9]})
      h.rd(8'h71, d);
      `CHK(d, {5'h00, flag[6], flag[4], flag[5]})
      h.rd(8'h73, d);
      `CHK(d, {5'h00, flag[10], 2'b00})
      h.clr();
      held = '0;
      upd();
      @(negedge sys_clk_in);
      `CHK(analog_clear, 1'b1)
      repeat (3) @(negedge sys_clk_in);
      chk_out();
      `CHK(analog_clear, 1'b0)
    end
    $display("random test done");
    tally_and_finish();
  end
endmodule // frml_fault_report_tb
